// *** common/toi_pkg.sv ***
package toi_pkg;

  // framing mode of the port framer
  typedef enum logic [1:0] {
    TOI_MODE_CLEAR = 2'b00,
    TOI_MODE_T3    = 2'b01,
    TOI_MODE_G751  = 2'b10,
    TOI_MODE_G832  = 2'b11
  } toi_mode_e;

  // one overhead position as taken from the port
  typedef struct packed {
    logic sof;
    logic enable;
    logic data;
  } toi_pair_s;

  localparam int TOI_PAIR_W = $bits(toi_pair_s);

  // overhead positions per sequence
  localparam logic [5:0] TOI_SEQ_LEN_T3   = 6'h38;
  localparam logic [5:0] TOI_SEQ_LEN_G751 = 6'h0c;
  localparam logic [5:0] TOI_SEQ_LEN_G832 = 6'h38;
  localparam logic [5:0] TOI_POS_FIRST    = 6'h00;

  // overhead clock half period in sys_clk cycles
  localparam logic [7:0] TOI_HALF_CYCLES_DEF = 8'h10;
  localparam logic [7:0] TOI_COUNT_ONE       = 8'h01;
  localparam logic [7:0] TOI_COUNT_ZERO      = 8'h00;

  localparam int TOI_BUF_DEPTH = 2;

  function automatic logic [5:0] toi_seq_len(input toi_mode_e mode);
    case (mode)
      TOI_MODE_T3:   toi_seq_len = TOI_SEQ_LEN_T3;
      TOI_MODE_G751: toi_seq_len = TOI_SEQ_LEN_G751;
      TOI_MODE_G832: toi_seq_len = TOI_SEQ_LEN_G832;
      default:       toi_seq_len = TOI_SEQ_LEN_T3;
    endcase
  endfunction : toi_seq_len

endpackage : toi_pkg

// *** core/toi_pair_fifo.sv ***
`timescale 1ns/100ps
`default_nettype none
module toi_pair_fifo #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic [AW:0]      count_reg;
  logic             doWrite;
  logic             doRead;

  assign inReady  = (count_reg != FULL_CNT);
  assign outValid = (count_reg != '0);
  assign outData  = mem_reg[rdPtr_reg];
  assign doWrite  = inValid && inReady;
  assign doRead   = outValid && outReady;

  always_ff @(posedge clk) begin
    if (doWrite) begin
      mem_reg[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (doWrite) begin
        wrPtr_reg <= (wrPtr_reg == LAST_IDX) ? '0 : AW'(wrPtr_reg + 1'b1);
      end
      if (doRead) begin
        rdPtr_reg <= (rdPtr_reg == LAST_IDX) ? '0 : AW'(rdPtr_reg + 1'b1);
      end
      if (doWrite && !doRead) begin
        count_reg <= (AW + 1)'(count_reg + 1'b1);
      end else if (doRead && !doWrite) begin
        count_reg <= (AW + 1)'(count_reg - 1'b1);
      end
    end
  end
endmodule : toi_pair_fifo
`default_nettype wire

// *** core/toi_tx_overhead_port.sv ***
`timescale 1ns/100ps
`default_nettype none
module toi_tx_overhead_port #(
  parameter logic [7:0] HALF_CYCLES = toi_pkg::TOI_HALF_CYCLES_DEF
) (
  input  wire logic               sys_clk,
  input  wire logic               reset,
  input  wire toi_pkg::toi_mode_e framingMode,
  input  wire logic               invertDataIn,
  input  wire logic               invertEnableIn,
  input  wire logic               invertClockOut,
  input  wire logic               invertStartOut,
  input  wire logic               txOverheadDataIn,
  input  wire logic               txOverheadInsertEnable,
  output logic                    txOverheadClockOut,
  output logic                    txOverheadSequenceStart,
  input  wire logic               lineClk,
  input  wire logic               framerBit,
  input  wire logic               framerOhPos,
  input  wire logic               framerFirstOh,
  output logic                    lineTxBit
);
  import toi_pkg::*;

  // polarity applied at a pin, both directions
  function automatic logic toi_pol(input logic level, input logic invert);
    toi_pol = level ^ invert;
  endfunction : toi_pol

  typedef enum logic [1:0] {
    TOI_PH_IDLE = 2'b00,
    TOI_PH_HIGH = 2'b01,
    TOI_PH_LOW  = 2'b10
  } toi_phase_e;

  ////////////////////////////////////////////////////////////////////////////////
  // pin input synchronisers
  logic       dataMeta_reg;
  logic       dataSync_reg;
  logic       enMeta_reg;
  logic       enSync_reg;
  logic       framed;
  toi_pair_s  sampledPair;

  always_ff @(posedge sys_clk) begin
    dataMeta_reg <= txOverheadDataIn;
    dataSync_reg <= dataMeta_reg;
  end

  always_ff @(posedge sys_clk) begin
    enMeta_reg <= txOverheadInsertEnable;
    enSync_reg <= enMeta_reg;
  end

  assign framed = (framingMode != TOI_MODE_CLEAR);

  ////////////////////////////////////////////////////////////////////////////////
  // overhead clock divider and sequence position
  toi_phase_e phase_reg;
  logic [7:0] halfCnt_reg;
  logic [5:0] pos_reg;
  logic       seqStart_reg;
  logic       clkLevel_reg;
  logic       clkPin_reg;
  logic       startPin_reg;
  logic       halfDone;
  logic       fallEdge;
  logic       bufInReady;
  logic [5:0] seqLast;
  logic       seqWrap;

  assign halfDone = (halfCnt_reg == TOI_COUNT_ONE);
  assign seqLast  = 6'(toi_seq_len(framingMode) - 1'b1);
  assign seqWrap  = (pos_reg >= seqLast);
  // a full buffer stalls the clock high rather than dropping a position
  assign fallEdge = (phase_reg == TOI_PH_HIGH) && halfDone && bufInReady && framed;
  // tag with start level seen by the far end at this edge
  assign sampledPair = '{sof:    seqStart_reg,
                         enable: toi_pol(enSync_reg, invertEnableIn),
                         data:   toi_pol(dataSync_reg, invertDataIn)};

  always_ff @(posedge sys_clk) begin
    if (reset || !framed) begin
      phase_reg    <= TOI_PH_IDLE;
      halfCnt_reg  <= HALF_CYCLES;
      clkLevel_reg <= 1'b0;
    end else begin
      case (phase_reg)
        TOI_PH_IDLE: begin
          phase_reg    <= TOI_PH_HIGH;
          halfCnt_reg  <= HALF_CYCLES;
          clkLevel_reg <= 1'b1;
        end
        TOI_PH_HIGH: begin
          if (!halfDone) begin
            halfCnt_reg <= 8'(halfCnt_reg - TOI_COUNT_ONE);
          end else if (fallEdge) begin
            phase_reg    <= TOI_PH_LOW;
            halfCnt_reg  <= HALF_CYCLES;
            clkLevel_reg <= 1'b0;
          end
        end
        TOI_PH_LOW: begin
          if (!halfDone) begin
            halfCnt_reg <= 8'(halfCnt_reg - TOI_COUNT_ONE);
          end else begin
            phase_reg    <= TOI_PH_HIGH;
            halfCnt_reg  <= HALF_CYCLES;
            clkLevel_reg <= 1'b1;
          end
        end
        default: begin
          phase_reg    <= TOI_PH_IDLE;
          halfCnt_reg  <= HALF_CYCLES;
          clkLevel_reg <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || !framed) begin
      pos_reg <= TOI_POS_FIRST;
    end else if (fallEdge) begin
      pos_reg <= seqWrap ? TOI_POS_FIRST : 6'(pos_reg + 1'b1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || !framed) begin
      seqStart_reg <= 1'b1;
    end else if (fallEdge) begin
      seqStart_reg <= seqWrap;
    end
  end

  // pins hold their inactive level through reset, so no false edge follows it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      clkPin_reg <= invertClockOut;
    end else begin
      clkPin_reg <= toi_pol(clkLevel_reg, invertClockOut);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      startPin_reg <= invertStartOut;
    end else begin
      startPin_reg <= toi_pol(seqStart_reg && framed, invertStartOut);
    end
  end

  assign txOverheadClockOut      = clkPin_reg;
  assign txOverheadSequenceStart = startPin_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // two-entry buffer and handshake into the line domain
  toi_pair_s  bufOut;
  logic       bufOutValid;
  logic       xferBusy;
  logic       sendXfer;
  toi_pair_s  xfer_reg;
  logic       reqTgl_reg;
  logic       ackMeta_reg;
  logic       ackSync_reg;
  logic       ackTgl_reg;

  toi_pair_fifo #(
    .WIDTH (TOI_PAIR_W),
    .DEPTH (TOI_BUF_DEPTH)
  ) u_pair_fifo (
    .clk      (sys_clk),
    .reset    (reset || !framed),
    .inValid  (fallEdge),
    .inReady  (bufInReady),
    .inData   (sampledPair),
    .outValid (bufOutValid),
    .outReady (!xferBusy),
    .outData  (bufOut)
  );

  assign xferBusy = (reqTgl_reg != ackSync_reg);
  assign sendXfer = bufOutValid && !xferBusy;

  always_ff @(posedge sys_clk) begin
    ackMeta_reg <= ackTgl_reg;
    ackSync_reg <= ackMeta_reg;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reqTgl_reg <= 1'b0;
    end else if (sendXfer) begin
      reqTgl_reg <= !reqTgl_reg;
    end
  end

  // xfer_reg stays still while a request is outstanding
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      xfer_reg <= '0;
    end else if (sendXfer) begin
      xfer_reg <= bufOut;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // line domain
  logic       lrstMeta_reg;
  logic       lineReset_reg;
  logic       reqMeta_reg;
  logic       reqSync_reg;
  logic [1:0] modeMeta_reg;
  logic [1:0] modeSync_reg;
  toi_pair_s  slot_reg;
  logic       slotValid_reg;
  logic       txBit_reg;
  logic       reqPending;
  logic       lineFramed;
  logic       useSlot;
  logic       popSlot;
  logic       loadSlot;
  logic       insertNow;

  // reset, request toggle and mode each cross by two flops
  always_ff @(posedge lineClk) begin
    lrstMeta_reg  <= reset;
    lineReset_reg <= lrstMeta_reg;
  end

  always_ff @(posedge lineClk) begin
    reqMeta_reg <= reqTgl_reg;
    reqSync_reg <= reqMeta_reg;
  end

  always_ff @(posedge lineClk) begin
    modeMeta_reg <= framingMode;
    modeSync_reg <= modeMeta_reg;
  end

  assign reqPending = (reqSync_reg != ackTgl_reg);
  assign lineFramed = (modeSync_reg != TOI_MODE_CLEAR);
  // slot used only when it lines up with the framer's sequence
  assign useSlot = framerOhPos && slotValid_reg && (slot_reg.sof == framerFirstOh);
  // a stale slot at the framer's first position is dropped
  assign popSlot = framerOhPos && slotValid_reg && (useSlot || framerFirstOh);
  assign loadSlot = (!slotValid_reg || popSlot) && reqPending;
  assign insertNow = lineFramed && useSlot && slot_reg.enable;

  always_ff @(posedge lineClk) begin
    if (lineReset_reg) begin
      ackTgl_reg <= 1'b0;
    end else if (loadSlot) begin
      ackTgl_reg <= !ackTgl_reg;
    end
  end

  // a load in the same cycle as a pop wins
  always_ff @(posedge lineClk) begin
    if (lineReset_reg) begin
      slotValid_reg <= 1'b0;
    end else if (loadSlot) begin
      slotValid_reg <= 1'b1;
    end else if (popSlot) begin
      slotValid_reg <= 1'b0;
    end
  end

  always_ff @(posedge lineClk) begin
    if (lineReset_reg) begin
      slot_reg <= '0;
    end else if (loadSlot) begin
      slot_reg <= xfer_reg;
    end
  end

  always_ff @(posedge lineClk) begin
    if (lineReset_reg) begin
      txBit_reg <= 1'b0;
    end else if (insertNow) begin
      txBit_reg <= slot_reg.data;
    end else begin
      txBit_reg <= framerBit;
    end
  end

  assign lineTxBit = txBit_reg;
endmodule : toi_tx_overhead_port
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
  import toi_pkg::*;
  logic      sys_clk = 1'h0, lineClk = 1'h0, reset = 1'h1;
  toi_mode_e framingMode = TOI_MODE_CLEAR;
  logic      invertDataIn = 1'h0, invertEnableIn = 1'h0, invertClockOut = 1'h0, invertStartOut = 1'h0;
  logic      framerBit = 1'h0, framerOhPos = 1'h0, framerFirstOh = 1'h0;
  logic      txOverheadDataIn, txOverheadInsertEnable, txOverheadClockOut;
  logic      txOverheadSequenceStart, lineTxBit;
  int        err_count = 0, n_checks = 0;
  always #2 sys_clk = ~sys_clk;
  initial begin
    #1.3;
    forever #6 lineClk = ~lineClk;
  end
  toi_tx_overhead_port #(.HALF_CYCLES(8'h08)) dut_u (
    .sys_clk(sys_clk), .reset(reset), .framingMode(framingMode),
    .invertDataIn(invertDataIn), .invertEnableIn(invertEnableIn),
    .invertClockOut(invertClockOut), .invertStartOut(invertStartOut),
    .txOverheadDataIn(txOverheadDataIn), .txOverheadInsertEnable(txOverheadInsertEnable),
    .txOverheadClockOut(txOverheadClockOut), .txOverheadSequenceStart(txOverheadSequenceStart),
    .lineClk(lineClk), .framerBit(framerBit), .framerOhPos(framerOhPos),
    .framerFirstOh(framerFirstOh), .lineTxBit(lineTxBit));
  toi_far_end_model far_u (
    .txOverheadClockOut(txOverheadClockOut), .txOverheadSequenceStart(txOverheadSequenceStart),
    .invertDataIn(invertDataIn), .invertEnableIn(invertEnableIn),
    .invertClockOut(invertClockOut), .invertStartOut(invertStartOut),
    .txOverheadDataIn(txOverheadDataIn), .txOverheadInsertEnable(txOverheadInsertEnable));
  ////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  task automatic chk(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : chk
  // config only changes under reset
  task automatic restart(input toi_mode_e m, input logic [3:0] inv);
    @(posedge sys_clk);
    reset       <= 1'h1;
    framingMode <= m;
    {invertDataIn, invertEnableIn, invertClockOut, invertStartOut} <= inv;
    repeat (20) @(posedge sys_clk);
    reset <= 1'h0;
  endtask : restart
  // one overhead bit then one payload bit, widely spaced
  task automatic lstep(input logic first, input logic fb, output logic ohGot, output logic payGot);
    @(posedge lineClk);
    framerOhPos   <= 1'h1;
    framerFirstOh <= first;
    framerBit     <= fb;
    @(posedge lineClk);
    framerOhPos   <= 1'h0;
    framerFirstOh <= 1'h0;
    framerBit     <= fb;
    @(negedge lineClk);
    ohGot = lineTxBit;
    @(negedge lineClk);
    payGot = lineTxBit;
    repeat (5) @(posedge lineClk);
  endtask : lstep
  // first sequence aligns the buffer and is not judged
  task automatic run_seq(input logic framed, input logic [5:0] len, input int nseq);
    logic [5:0] k;
    logic       d, e, oh, pay;
    repeat (16) @(posedge lineClk);
    for (int s = 0; s < nseq; s++) begin
      for (int i = 0; i < len; i++) begin
        k = i[5:0];
        d = k[0] ^ k[2];
        e = k[1] | k[3];
        lstep(k == 6'h00, ~d, oh, pay);
        if (s > 0) begin
          chk("overhead bit", (framed && e) ? d : ~d, oh);
          chk("payload bit", ~d, pay);
        end
      end
    end
  endtask : run_seq
  task automatic test_t3;
    restart(TOI_MODE_T3, 4'h0);
    run_seq(1'h1, TOI_SEQ_LEN_T3, 2);
    $display("test t3 done");
  endtask : test_t3
  task automatic test_g751;
    restart(TOI_MODE_G751, 4'h0);
    run_seq(1'h1, TOI_SEQ_LEN_G751, 3);
    $display("test g751 done");
  endtask : test_g751
  task automatic test_g832_inv;
    restart(TOI_MODE_G832, 4'hf);
    run_seq(1'h1, TOI_SEQ_LEN_G832, 2);
    $display("test g832 inverted done");
  endtask : test_g832_inv
  task automatic test_clear;
    restart(TOI_MODE_CLEAR, 4'h3);
    run_seq(1'h0, TOI_SEQ_LEN_G751, 2);
    chk("clock pin idle", 1'h1, txOverheadClockOut);
    chk("start pin idle", 1'h1, txOverheadSequenceStart);
    $display("test clear done");
  endtask : test_clear
  initial begin
    repeat (100000) @(posedge sys_clk);
    $display("timeout");
    err_count++;
    results();
  end
  initial begin
    test_t3();
    test_g751();
    test_g832_inv();
    test_clear();
    results();
  end
endmodule : tb
`default_nettype wire

// *** verif/toi_far_end_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module toi_far_end_model (
  input  wire logic txOverheadClockOut,
  input  wire logic txOverheadSequenceStart,
  input  wire logic invertDataIn,
  input  wire logic invertEnableIn,
  input  wire logic invertClockOut,
  input  wire logic invertStartOut,
  output logic      txOverheadDataIn,
  output logic      txOverheadInsertEnable
);
  logic       ohClk;
  logic [5:0] pos;
  assign ohClk = txOverheadClockOut ^ invertClockOut;
  initial begin
    txOverheadDataIn       = 1'h0;
    txOverheadInsertEnable = 1'h0;
    pos                    = 6'h00;
  end
  // far end reacts to the rising overhead clock only
  always @(posedge ohClk) begin
    pos = (txOverheadSequenceStart ^ invertStartOut) ? 6'h00 : pos + 6'h01;
    txOverheadDataIn       <= (pos[0] ^ pos[2]) ^ invertDataIn;
    txOverheadInsertEnable <= (pos[1] | pos[3]) ^ invertEnableIn;
  end
endmodule : toi_far_end_model
`default_nettype wire

// *** verif/toi_tx_overhead_port_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module toi_tx_overhead_port_props
  import toi_pkg::*;
#(
  parameter logic [7:0] HALF_CYCLES = TOI_HALF_CYCLES_DEF
) (
  input wire logic               sys_clk,
  input wire logic               reset,
  input wire toi_pkg::toi_mode_e framingMode,
  input wire logic               invertClockOut,
  input wire logic               invertStartOut,
  input wire logic               txOverheadClockOut,
  input wire logic               txOverheadSequenceStart,
  input wire logic               lineClk,
  input wire logic               framerBit,
  input wire logic               framerOhPos,
  input wire logic               lineTxBit
);
  logic       ohClk, startL, framed, rise, fall, startUp;
  logic       clkPrev_reg, startPrev_reg, seqSeen_reg, runSeen_reg;
  logic [7:0] runLen_reg;
  logic [5:0] falls_reg, seqLen;
  logic [3:0] lineRst_reg;
  assign ohClk   = txOverheadClockOut ^ invertClockOut;
  assign startL  = txOverheadSequenceStart ^ invertStartOut;
  assign framed  = framingMode != TOI_MODE_CLEAR;
  assign rise    = ~clkPrev_reg & ohClk;
  assign fall    = clkPrev_reg & ~ohClk;
  assign startUp = fall & startL & ~startPrev_reg;
  assign seqLen  = (framingMode == TOI_MODE_G751) ? TOI_SEQ_LEN_G751
                 : (framingMode == TOI_MODE_G832) ? TOI_SEQ_LEN_G832 : TOI_SEQ_LEN_T3;
  // length of the phase that just ended, saturating
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      clkPrev_reg <= 1'h0;
      runLen_reg  <= 8'h00;
      runSeen_reg <= 1'h0;
    end else begin
      clkPrev_reg <= ohClk;
      runLen_reg  <= (rise | fall) ? 8'h01 : (runLen_reg == 8'hff) ? runLen_reg : runLen_reg + 8'h01;
      if (fall) runSeen_reg <= 1'h1;
    end
  end
  // falling edges per overhead sequence
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      startPrev_reg <= 1'h0;
      falls_reg     <= 6'h00;
      seqSeen_reg   <= 1'h0;
    end else begin
      startPrev_reg <= startL;
      if (startUp) begin
        falls_reg   <= 6'h01;
        seqSeen_reg <= 1'h1;
      end else if (fall) falls_reg <= falls_reg + 6'h01;
    end
  end
  always_ff @(posedge lineClk) lineRst_reg <= {lineRst_reg[2:0], reset};

  a_clear_clk_idle: assert property (@(posedge sys_clk) disable iff (reset)
    (!framed && !$past(reset)) |-> txOverheadClockOut == invertClockOut) else $error("clock moves in clear mode");
  a_clear_start_idle: assert property (@(posedge sys_clk) disable iff (reset)
    (!framed && !$past(reset)) |-> txOverheadSequenceStart == invertStartOut) else $error("start set in clear mode");
  a_low_phase_len: assert property (@(posedge sys_clk) disable iff (reset)
    (rise && runSeen_reg) |-> runLen_reg == HALF_CYCLES) else $error("low phase length wrong");
  a_high_phase_min: assert property (@(posedge sys_clk) disable iff (reset)
    (fall && runSeen_reg) |-> runLen_reg >= HALF_CYCLES) else $error("high phase too short");
  a_start_at_fall: assert property (@(posedge sys_clk) disable iff (reset)
    (framed && !$past(reset) && !$past(reset, 2) && startL != startPrev_reg) |-> fall)
    else $error("start changed off the falling edge");
  a_start_one_period: assert property (@(posedge sys_clk) disable iff (reset)
    (fall && startPrev_reg && seqSeen_reg) |-> !startL) else $error("start held past first position");
  a_seq_len: assert property (@(posedge sys_clk) disable iff (reset)
    (startUp && seqSeen_reg) |-> falls_reg == seqLen) else $error("sequence length wrong");
  a_clear_line_pass: assert property (@(posedge lineClk) disable iff (reset)
    (!framed && lineRst_reg == 4'h0) |-> lineTxBit == $past(framerBit)) else $error("clear mode altered");
  a_payload_pass: assert property (@(posedge lineClk) disable iff (reset)
    (!$past(framerOhPos) && lineRst_reg == 4'h0) |-> lineTxBit == $past(framerBit))
    else $error("payload bit altered");
  c_t3_seq: cover property (@(posedge sys_clk) startUp && seqSeen_reg && framingMode == TOI_MODE_T3);
  c_g751_seq: cover property (@(posedge sys_clk) startUp && seqSeen_reg && framingMode == TOI_MODE_G751);
  c_stretch: cover property (@(posedge sys_clk) fall && runLen_reg > HALF_CYCLES);
endmodule : toi_tx_overhead_port_props
bind toi_tx_overhead_port toi_tx_overhead_port_props #(.HALF_CYCLES(HALF_CYCLES)) props_u (
  .sys_clk(sys_clk), .reset(reset), .framingMode(framingMode),
  .invertClockOut(invertClockOut), .invertStartOut(invertStartOut),
  .txOverheadClockOut(txOverheadClockOut), .txOverheadSequenceStart(txOverheadSequenceStart),
  .lineClk(lineClk), .framerBit(framerBit), .framerOhPos(framerOhPos), .lineTxBit(lineTxBit));
`default_nettype wire
